// ---- rtl/pmsw_seq.sv ----
// Power-mode sequencer: halt entry, clock gating, flags and wake-up.
// Assumes core strobes on clk; port A pins are asynchronous and synchronised here.
//
// Functional notes
// - Halt, idle off, watchdog/detector on: light sleep
// - Halt, idle on, keep off: low idle
// - Halt, idle on, keep on: full idle
// - Sleep keeps memory, registers and ports
// - Sleep or idle entry clears watchdog counter
// - Halt sets power-down, clears time-out flag
// - Wake on port edge, interrupt, watchdog
// - Watchdog wake sets time-out, resets PC/SP
// - Power-down cleared by reset or watchdog clear
// - Per-pin wake enable; resume after halt
// - Disabled or stack-full interrupt: resume, pending
// - Enabled interrupt with room: normal response
// - Pre-set interrupt request cannot wake
// - Oscillators share one start-up timer sequentially
// - First instruction waits for high oscillator ready
// - Fast wake runs from low oscillator first
// - Peripherals follow system clock to sub
// - Watchdog clock follows watchdog enable; sub clock too, but forced on in idle and fast wake
// - Halt, all off: deep sleep, stop everything
// - Fast wake: sub clock until 128 cycles
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module pmsw_seq (
    input wire logic clk,
    input wire logic srst,
    input wire logic [pmsw_pkg::ADDR_W-1:0] addr,
    input wire logic [pmsw_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [pmsw_pkg::DATA_W-1:0] rdata,
    input wire logic halt,
    input wire logic clr_wdt,
    input wire logic wdt_enabled,
    input wire logic lvd_enabled,
    input wire logic wdt_overflow,
    input wire logic irq_req,
    input wire logic irq_pre_set,
    input wire logic irq_enabled,
    input wire logic stack_full,
    input wire logic [pmsw_pkg::PA_W-1:0] porta_in,
    output logic cpu_run,
    output logic resume_pulse,
    output logic irq_take,
    output logic pc_sp_reset,
    output logic wdt_clear,
    output logic sysclk_on_sub,
    output pmsw_pkg::pmsw_clk_en_t clk_en
);

    ////////////////////////////////////////////////////////////////////////////
    pmsw_pkg::pmsw_regs_t r;
    pmsw_pkg::pmsw_regs_t next_r;

    function automatic logic is_low_power(input pmsw_pkg::pmsw_state_t s);
        is_low_power = (s == pmsw_pkg::PMSW_LIGHT) || (s == pmsw_pkg::PMSW_DEEP)
            || (s == pmsw_pkg::PMSW_LOW_IDLE) || (s == pmsw_pkg::PMSW_FULL_IDLE);
    endfunction

    function automatic pmsw_pkg::pmsw_clk_en_t gates(input pmsw_pkg::pmsw_state_t s,
                                                     input logic wdt_on);
        gates.wdt = wdt_on;
        gates.sub = wdt_on;
        case (s)
            pmsw_pkg::PMSW_DEEP: begin
                gates = '0;
            end
            pmsw_pkg::PMSW_LIGHT: begin
                gates.sys = 1'b0;
                gates.tbase = 1'b0;
            end
            pmsw_pkg::PMSW_LOW_IDLE: begin
                gates.sys = 1'b0;
                gates.tbase = 1'b1;
                gates.sub = 1'b1;
            end
            pmsw_pkg::PMSW_FULL_IDLE: begin
                gates.sys = 1'b1;
                gates.tbase = 1'b1;
                gates.sub = 1'b1;
            end
            pmsw_pkg::PMSW_WAKE_HI: begin
                gates.sys = 1'b0;
                gates.tbase = 1'b0;
            end
            default: begin
                gates.sys = 1'b1;
                gates.tbase = 1'b1;
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic [pmsw_pkg::PA_W-1:0] pa_fall;
    logic wake_irq;
    logic wake_any;

    // Edge detect reads the second and third stages only
    assign pa_fall = r.pa_s3 & ~r.pa_s2 & r.wake_en;
    assign wake_irq = irq_req & ~irq_pre_set;
    assign wake_any = (|pa_fall) | wake_irq | wdt_overflow;

    always_comb begin
        next_r = r;
        next_r.pa_s1 = porta_in;
        next_r.pa_s2 = r.pa_s1;
        next_r.pa_s3 = r.pa_s2;
        next_r.wdt_clr = 1'b0;
        next_r.pc_rst = 1'b0;
        next_r.irq_take = 1'b0;
        next_r.resume = 1'b0;
        next_r.rdata = '0;

        if (wr) begin
            case (addr)
                pmsw_pkg::OFS_CTRL: next_r.ctrl = wdata;
                pmsw_pkg::OFS_WAKE_EN: next_r.wake_en = wdata[pmsw_pkg::PA_W-1:0];
                default: ;
            endcase
        end
        if (rd) begin
            case (addr)
                pmsw_pkg::OFS_CTRL: next_r.rdata = r.ctrl;
                pmsw_pkg::OFS_STATUS: next_r.rdata = {4'h0, r.on_sub, r.hrdy, r.to, r.power_down_flag};
                pmsw_pkg::OFS_WAKE_EN: next_r.rdata = r.wake_en;
                pmsw_pkg::OFS_STATE: next_r.rdata = {5'h00, r.st};
                default: next_r.rdata = '0;
            endcase
        end

        if (clr_wdt) begin
            next_r.power_down_flag = 1'b0;
        end

        case (r.st)
            pmsw_pkg::PMSW_RUN: begin
                if (halt) begin
                    next_r.power_down_flag = 1'b1;
                    next_r.to = 1'b0;
                    next_r.wdt_clr = 1'b1;
                    // Memory and ports untouched: only gates change, except deep sleep also clears hrdy and lrdy
                    if (r.ctrl[pmsw_pkg::CTRL_IDLE_SEL]) begin
                        next_r.st = r.ctrl[pmsw_pkg::CTRL_SYSCLK_KEEP] ?
                            pmsw_pkg::PMSW_FULL_IDLE : pmsw_pkg::PMSW_LOW_IDLE;
                    end else if (wdt_enabled || lvd_enabled) begin
                        next_r.st = pmsw_pkg::PMSW_LIGHT;
                    end else begin
                        next_r.st = pmsw_pkg::PMSW_DEEP;
                        next_r.hrdy = 1'b0;
                        next_r.lrdy = 1'b0;
                    end
                end
            end
            pmsw_pkg::PMSW_LIGHT, pmsw_pkg::PMSW_DEEP,
            pmsw_pkg::PMSW_LOW_IDLE, pmsw_pkg::PMSW_FULL_IDLE: begin
                if (wake_any) begin
                    if (wdt_overflow) begin
                        next_r.to = 1'b1;
                        next_r.pc_rst = 1'b1;
                    end else if (wake_irq && irq_enabled && !stack_full) begin
                        next_r.irq_take = 1'b1;
                    end else begin
                        next_r.resume = 1'b1;
                    end
                    next_r.osc_startup_timer = '0;
                    if (r.st == pmsw_pkg::PMSW_DEEP) begin
                        next_r.st = pmsw_pkg::PMSW_WAKE_HI;
                    end else if (r.st == pmsw_pkg::PMSW_LIGHT
                                 && r.ctrl[pmsw_pkg::CTRL_HXT_SEL]
                                 && r.ctrl[pmsw_pkg::CTRL_FAST_WAKE]) begin
                        next_r.on_sub = 1'b1;
                        next_r.hrdy = 1'b0;
                        next_r.st = pmsw_pkg::PMSW_WAKE_HI;
                    end else begin
                        next_r.st = pmsw_pkg::PMSW_RUN;
                    end
                end
            end
            pmsw_pkg::PMSW_WAKE_HI: begin
                next_r.osc_startup_timer = r.osc_startup_timer + 12'h001;
                if (r.osc_startup_timer == pmsw_pkg::HIGH_OSC_SST - 12'h001) begin
                    next_r.hrdy = 1'b1;
                    next_r.on_sub = 1'b0;
                    next_r.osc_startup_timer = '0;
                    next_r.st = r.lrdy ? pmsw_pkg::PMSW_RUN : pmsw_pkg::PMSW_WAKE_LO;
                end
            end
            pmsw_pkg::PMSW_WAKE_LO: begin
                // Core runs already; low crystal counts after the high one
                next_r.osc_startup_timer = r.osc_startup_timer + 12'h001;
                if (r.osc_startup_timer == pmsw_pkg::LOW_OSC_SST - 12'h001) begin
                    next_r.lrdy = 1'b1;
                    next_r.st = pmsw_pkg::PMSW_RUN;
                end
            end
            default: next_r.st = pmsw_pkg::PMSW_RUN;
        endcase

        next_r.clk_en = gates(next_r.st, wdt_enabled);
        if (next_r.on_sub) begin
            next_r.clk_en.sub = 1'b1;
            next_r.clk_en.sys = 1'b1;
            next_r.clk_en.tbase = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            r.st <= pmsw_pkg::PMSW_WAKE_HI;
            r.ctrl <= pmsw_pkg::CTRL_RESET;
            r.wake_en <= pmsw_pkg::WAKE_EN_RESET;
            r.pa_s1 <= '1;
            r.pa_s2 <= '1;
            r.pa_s3 <= '1;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core runs only when high oscillator ready or on the temporary sub clock
    assign cpu_run = (r.st == pmsw_pkg::PMSW_RUN) ||
                     (r.st == pmsw_pkg::PMSW_WAKE_LO) || r.on_sub;
    assign rdata = r.rdata;
    assign resume_pulse = r.resume;
    assign irq_take = r.irq_take;
    assign pc_sp_reset = r.pc_rst;
    assign wdt_clear = r.wdt_clr;
    assign sysclk_on_sub = r.on_sub;
    assign clk_en = r.clk_en;

endmodule // pmsw_seq

`default_nettype wire

// ---- inc/pmsw_pkg.sv ----
// Package for the power-mode sleep/wake sequencer: constants, types, state.
// Assumes a single 200 MHz clock domain and a plain register port.
package pmsw_pkg;

    localparam int CLK_MHZ = 200;
    localparam int PA_W = 8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_WAKE_EN = 4'h2;
    localparam logic [3:0] OFS_STATE = 4'h3;

    // Control register fields
    localparam int CTRL_IDLE_SEL = 0;
    localparam int CTRL_SYSCLK_KEEP = 1;
    localparam int CTRL_FAST_WAKE = 2;
    localparam int CTRL_HXT_SEL = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] WAKE_EN_RESET = 8'h00;

    // Status register fields
    localparam int STAT_PDF = 0;
    localparam int STAT_TO = 1;
    localparam int STAT_HRDY = 2;
    localparam int STAT_SUBSYS = 3;

    // Start-up counts in clock cycles
    localparam logic [11:0] HIGH_OSC_SST = 12'h080;
    localparam logic [11:0] LOW_OSC_SST = 12'h400;

    // Gray coded in the order listed here, not along the entry and wake transitions
    typedef enum logic [2:0] {
        PMSW_RUN = 3'b000,
        PMSW_LIGHT = 3'b001,
        PMSW_DEEP = 3'b011,
        PMSW_LOW_IDLE = 3'b010,
        PMSW_FULL_IDLE = 3'b110,
        PMSW_WAKE_HI = 3'b111,
        PMSW_WAKE_LO = 3'b101
    } pmsw_state_t;

    typedef struct packed {
        logic sys;
        logic tbase;
        logic sub;
        logic wdt;
    } pmsw_clk_en_t;

    typedef struct packed {
        pmsw_state_t st;
        logic [7:0] ctrl;
        logic [PA_W-1:0] wake_en;
        logic power_down_flag;
        logic to;
        logic hrdy;
        logic lrdy;
        logic on_sub;
        logic [11:0] osc_startup_timer;
        logic [PA_W-1:0] pa_s1;
        logic [PA_W-1:0] pa_s2;
        logic [PA_W-1:0] pa_s3;
        logic [7:0] rdata;
        logic wdt_clr;
        logic pc_rst;
        logic irq_take;
        logic resume;
        pmsw_clk_en_t clk_en;
    } pmsw_regs_t;

endpackage

// ---- test/pmsw_seq_assertions.sv ----
// Checker for the power-mode sequencer: entry gates, wake pulses, register port.
// Assumes it is bound to pmsw_seq and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module pmsw_seq_assertions (
    input wire logic clk,
    input wire logic srst,
    input wire logic [pmsw_pkg::ADDR_W-1:0] addr,
    input wire logic [pmsw_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [pmsw_pkg::DATA_W-1:0] rdata,
    input wire logic halt,
    input wire logic wdt_enabled,
    input wire logic lvd_enabled,
    input wire logic wdt_overflow,
    input wire logic irq_enabled,
    input wire logic stack_full,
    input wire logic cpu_run,
    input wire logic resume_pulse,
    input wire logic irq_take,
    input wire logic pc_sp_reset,
    input wire logic wdt_clear,
    input wire pmsw_pkg::pmsw_clk_en_t clk_en
);
    logic [1:0] mode;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Shadow of idle select and keep bits, the checker cannot see the register
    always_ff @(posedge clk) begin
        if (srst) mode <= 2'b00;
        else if (wr && addr == pmsw_pkg::OFS_CTRL) mode <= wdata[1:0];
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_entry; wdt_clear |-> $past(halt) && !cpu_run; endproperty
    a_entry: assert property (p_entry) else $error("watchdog clear without halt entry");
    property p_light; wdt_clear && !mode[0] && $past(wdt_enabled || lvd_enabled) |-> !clk_en.sys && !clk_en.tbase; endproperty
    a_light: assert property (p_light) else $error("light sleep gates wrong");
    property p_low; wdt_clear && mode == 2'b01 |-> !clk_en.sys && clk_en.tbase && clk_en.sub; endproperty
    a_low: assert property (p_low) else $error("low idle gates wrong");
    property p_full; wdt_clear && mode == 2'b11 |-> clk_en.sys && clk_en.tbase && clk_en.sub; endproperty
    a_full: assert property (p_full) else $error("full idle gates wrong");
    property p_deep; wdt_clear && !mode[0] && !$past(wdt_enabled || lvd_enabled) |-> clk_en == 4'h0; endproperty
    a_deep: assert property (p_deep) else $error("deep sleep gates wrong");
    property p_one; $onehot0({pc_sp_reset, irq_take, resume_pulse}); endproperty
    a_one: assert property (p_one) else $error("two wake outcomes at once");
    property p_wdt; pc_sp_reset |-> $past(wdt_overflow); endproperty
    a_wdt: assert property (p_wdt) else $error("pc reset without overflow");
    property p_irq; irq_take |-> $past(irq_enabled && !stack_full) && !$past(wdt_overflow); endproperty
    a_irq: assert property (p_irq) else $error("interrupt taken without room");
    property p_unmap; rd && addr > pmsw_pkg::OFS_STATE |=> rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_idle_rd; !rd |=> rdata == 8'h00; endproperty
    a_idle_rd: assert property (p_idle_rd) else $error("read data outside answer cycle");
endmodule // pmsw_seq_assertions
bind pmsw_seq pmsw_seq_assertions u_chk (.*);
`default_nettype wire

// ---- test/pmsw_seq_tb.sv ----
// Self-checking bench for the power-mode sequencer: every halt mode and wake path.
// Assumes pmsw_pkg is compiled first; the checker is attached by bind.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pmsw_seq_tb;
    logic clk, srst, wr, rd, halt, clr_wdt, wdt_enabled, lvd_enabled, wdt_overflow, irq_req;
    logic irq_pre_set, irq_enabled, stack_full, cpu_run, resume_pulse, irq_take;
    logic pc_sp_reset, wdt_clear, sysclk_on_sub, rd_q;
    logic [pmsw_pkg::ADDR_W-1:0] addr;
    logic [pmsw_pkg::DATA_W-1:0] wdata, rdata, porta_in, v;
    pmsw_pkg::pmsw_clk_en_t clk_en;
    logic [7:0] rq_exp[$];
    logic [7:0] rq_msk[$];
    logic [2:0] wq[$];
    logic [31:0] seed = 32'hb3de_5ea4;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    localparam logic [1:0] CT[5] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h0};
    localparam logic [2:0] ST[5] = '{3'h1, 3'h2, 3'h6, 3'h3, 3'h1};
    localparam logic [2:0] WK[5] = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h4};
    pmsw_seq dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .halt(halt), .clr_wdt(clr_wdt), .wdt_enabled(wdt_enabled),
        .lvd_enabled(lvd_enabled), .wdt_overflow(wdt_overflow), .irq_req(irq_req),
        .irq_pre_set(irq_pre_set), .irq_enabled(irq_enabled), .stack_full(stack_full),
        .porta_in(porta_in), .cpu_run(cpu_run), .resume_pulse(resume_pulse),
        .irq_take(irq_take), .pc_sp_reset(pc_sp_reset), .wdt_clear(wdt_clear),
        .sysclk_on_sub(sysclk_on_sub), .clk_en(clk_en));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // A zero mask notes the read without judging it, for polling
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        rq_exp.push_back(e);
        rq_msk.push_back(m);
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    task automatic ev(input int k);
        @(posedge clk);
        case (k)
            0: halt <= 1'b1;
            1: wdt_overflow <= 1'b1;
            2: irq_req <= 1'b1;
            default: clr_wdt <= 1'b1;
        endcase
        @(posedge clk);
        {halt, wdt_overflow, irq_req, clr_wdt} <= 4'h0;
    endtask
    // Start-up counts are long, so the poll is bounded just past their sum of 1152 cycles
    task automatic wait_run();
        int n;
        n = 0;
        v = 8'hff;
        while (v !== 8'h00 && n < 600) begin
            rd_reg(pmsw_pkg::OFS_STATE, 8'h00, 8'h00);
            n++;
        end
        `CHK(v, 8'h00)
    endtask
    // A disabled neighbour pin falls first and must not wake
    task automatic port_wake();
        logic [2:0] p;
        logic [7:0] en;
        seed = xs(seed);
        p = seed[2:0];
        en = (seed[15:8] | (8'h01 << p)) & ~(8'h01 << (p ^ 3'h1));
        wr_reg(pmsw_pkg::OFS_WAKE_EN, en);
        rd_reg(pmsw_pkg::OFS_WAKE_EN, en, 8'hff);
        porta_in <= ~(8'h01 << (p ^ 3'h1));
        repeat (10) @(posedge clk);
        wq.push_back(3'b001);
        porta_in <= porta_in & ~(8'h01 << p);
        repeat (10) @(posedge clk);
        porta_in <= 8'hff;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        rd_q <= rd;
        cyc++;
        if (cyc == 40000) begin
            errors++;
            conclude();
        end
    end
    always @(negedge clk) begin
        if (rd_q && rq_exp.size() > 0) begin
            if (rq_msk[0] != 8'h00) `CHK(rdata & rq_msk[0], rq_exp[0] & rq_msk[0])
            void'(rq_exp.pop_front());
            void'(rq_msk.pop_front());
        end
        if (pc_sp_reset || irq_take || resume_pulse) begin
            `CHK({pc_sp_reset, irq_take, resume_pulse}, (wq.size() > 0) ? wq[0] : 3'b000)
            if (wq.size() > 0) void'(wq.pop_front());
        end
    end
    initial begin
        {srst, wr, rd, halt, clr_wdt, wdt_enabled, lvd_enabled, wdt_overflow} = 8'h80;
        {irq_req, irq_pre_set, irq_enabled, stack_full, rd_q} = 5'h0;
        addr = 4'h0;
        wdata = 8'h00;
        porta_in = 8'hff;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (100) @(posedge clk);
        `CHK(cpu_run, 1'b0)
        for (int n = 0; n < 100 && cpu_run !== 1'b1; n++) @(posedge clk);
        `CHK(cpu_run, 1'b1)
        rd_reg(pmsw_pkg::OFS_STATUS, 8'h04, 8'h07);
        wait_run();
        wr_reg(4'h5, 8'hff);
        for (int a = 4; a < 16; a++) rd_reg(a[3:0], 8'h00, 8'hff);
        for (int m = 0; m < 5; m++) begin
            wr_reg(pmsw_pkg::OFS_CTRL, {6'h00, CT[m]});
            wdt_enabled <= (m == 4);
            lvd_enabled <= (m == 0);
            irq_enabled <= (m >= 2);
            stack_full <= (m == 3);
            ev(0);
            repeat (2) @(posedge clk);
            rd_reg(pmsw_pkg::OFS_STATE, {5'h00, ST[m]}, 8'hff);
            rd_reg(pmsw_pkg::OFS_STATUS, 8'h01, 8'h03);
            if (m == 0) port_wake();
            else wq.push_back(WK[m]);
            if (m != 0) ev(m == 4 ? 1 : 2);
            wait_run();
        end
        rd_reg(pmsw_pkg::OFS_STATUS, 8'h03, 8'h03);
        ev(3);
        rd_reg(pmsw_pkg::OFS_STATUS, 8'h02, 8'h03);
        wr_reg(pmsw_pkg::OFS_CTRL, 8'h01);
        irq_pre_set <= 1'b1;
        ev(0);
        ev(2);
        repeat (8) @(posedge clk);
        rd_reg(pmsw_pkg::OFS_STATE, 8'h02, 8'hff);
        irq_pre_set <= 1'b0;
        port_wake();
        wait_run();
        wr_reg(pmsw_pkg::OFS_CTRL, 8'h0c);
        lvd_enabled <= 1'b1;
        irq_enabled <= 1'b0;
        ev(0);
        wq.push_back(3'b001);
        ev(2);
        repeat (2) @(posedge clk);
        `CHK(cpu_run, 1'b1)
        rd_reg(pmsw_pkg::OFS_STATUS, 8'h08, 8'h0c);
        wait_run();
        rd_reg(pmsw_pkg::OFS_STATUS, 8'h04, 8'h0c);
        `CHK(wq.size(), 0)
        conclude();
    end
endmodule // pmsw_seq_tb
`default_nettype wire
